/* src/bfs_sequencer.sv */
// Chosen here: the address map and strobed register access.
module bfs_sequencer
  import bfs_pkg::*;
#(
  parameter int SS_CLOCKS        = SS_CLOCKS_DEF,
  parameter int OC_HICCUP_CYCLES = OC_HICCUP_CYCLES_DEF,
  parameter int TH_HICCUP_CYCLES = TH_HICCUP_CYCLES_DEF
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              enablePin,
  input  wire logic              uvloOk,
  input  wire logic              bootReserveOk,
  input  wire logic              peakCurrentTrip,
  input  wire logic              srcLimitTrip,
  input  wire logic              sinkLimitTrip,
  input  wire logic              fbAbove118,
  input  wire logic              fbAbove104,
  input  wire logic              tempAbove165,
  input  wire logic              tempAbove155,
  input  wire logic              softStartAboveFb,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [31:0]       regWrData,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [31:0]       regRdData,
  output logic                   hsGate,
  output logic                   lsGate,
  output logic                   softStartActive,
  output logic                   overloadHiccup,
  output logic                   thermalShutdown
);

  localparam logic [HIC_W-1:0] OC_HIC_LAST = HIC_W'(OC_HICCUP_CYCLES - 1);
  localparam logic [HIC_W-1:0] TH_HIC_LAST = HIC_W'(TH_HICCUP_CYCLES - 1);
  localparam logic [SS_W-1:0]  SS_LAST     = SS_W'(SS_CLOCKS - 1);

  logic [FLAG_W-1:0]  flagRaw;
  logic [FLAG_W-1:0]  flagS;
  bfs_state_type      state_r, state_nxt;
  logic [PHASE_W-1:0] phase_r;
  logic [9:0]         ovldCnt_r, ovldCnt_nxt;
  logic [HIC_W-1:0]   hicCnt_r;
  logic [SS_W-1:0]    ssCnt_r;
  logic               ssActive_r;
  logic               hsOn_r, hsOn_nxt;
  logic               skip_r;
  logic               sinkOff_r;
  logic               limitSeen_r;
  logic               ovMask_r, ovMask_nxt;
  logic               hsGate_r, lsGate_r;
  logic [31:0]        ctrl_r;
  logic [31:0]        rdData_r;
  logic               ovlState_r, thermState_r;

  // gather pins into one bundle for the synchroniser
  assign flagRaw = {softStartAboveFb, tempAbove155, tempAbove165, fbAbove104, fbAbove118,
                    sinkLimitTrip, srcLimitTrip, peakCurrentTrip, bootReserveOk, uvloOk,
                    enablePin};

  bfs_flag_sync #(.W(FLAG_W)) uSync (
    .clock    (clock),
    .rst_n    (rst_n),
    .flagsIn  (flagRaw),
    .flagsOut (flagS)
  );

  // decoded conditions
  wire enabled    = flagS[F_ENABLE] & flagS[F_UVLO_OK] & ctrl_r[CTRL_RUN_BIT];
  wire bootOk     = flagS[F_BOOT_OK];
  wire peakHit    = flagS[F_PEAK];
  wire srcHit     = flagS[F_SRC_LIM];
  wire sinkHit    = flagS[F_SINK_LIM];
  wire tempHot    = flagS[F_TEMP_165];
  wire tempWarm   = flagS[F_TEMP_155];
  wire running    = (state_r == BFS_RUN);
  wire cycleStart = (phase_r == PHASE_FIRST);
  wire cycleEnd   = (phase_r == PHASE_LAST);
  wire limitCycle = limitSeen_r | srcHit | sinkHit;
  wire ovldTrip   = cycleEnd & limitCycle & (ovldCnt_r == OVERLOAD_LIMIT);
  wire ocHicDone  = cycleEnd & (hicCnt_r == OC_HIC_LAST);
  wire thHicDone  = cycleEnd & (hicCnt_r == TH_HIC_LAST);
  wire stateMove  = (state_nxt != state_r);

  // fixed switching cycle
  // the phase counter free-runs so the frequency never drifts with load
  always_ff @(posedge clock) begin
    if (!rst_n) phase_r <= PHASE_FIRST;
    else        phase_r <= cycleEnd ? PHASE_FIRST : phase_r + 7'h01;
  end

  // sequencing state
  always_comb begin
    state_nxt = state_r;
    if (!enabled) begin
      state_nxt = BFS_IDLE;
    end else if (tempHot) begin
      state_nxt = BFS_THERM_WAIT;
    end else begin
      case (state_r)
        BFS_IDLE: begin
          state_nxt = BFS_PREBIAS;
        end
        BFS_PREBIAS: begin
          if (flagS[F_SS_ABOVE_FB]) state_nxt = BFS_RUN;
        end
        BFS_RUN: begin
          if (ovldTrip) state_nxt = BFS_OC_HICCUP;
        end
        BFS_OC_HICCUP: begin
          if (ocHicDone) state_nxt = BFS_PREBIAS;
        end
        BFS_THERM_WAIT: begin
          if (!tempWarm) state_nxt = BFS_THERM_HICCUP;
        end
        BFS_THERM_HICCUP: begin
          if (tempWarm)       state_nxt = BFS_THERM_WAIT;
          else if (thHicDone) state_nxt = BFS_PREBIAS;
        end
        default: begin
          state_nxt = BFS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) state_r <= BFS_IDLE;
    else        state_r <= state_nxt;
  end

  // hiccup cycle count
  // one counter serves both hiccups; it restarts on every state change
  always_ff @(posedge clock) begin
    if (!rst_n)        hicCnt_r <= '0;
    else if (stateMove) hicCnt_r <= '0;
    else if (cycleEnd)  hicCnt_r <= hicCnt_r + 16'h0001;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ssCnt_r    <= '0;
      ssActive_r <= 1'b0;
    end else if (state_nxt == BFS_PREBIAS && state_r != BFS_PREBIAS) begin
      ssCnt_r    <= '0;
      ssActive_r <= 1'b1;
    end else if (!enabled) begin
      ssActive_r <= 1'b0;
    end else if (ssActive_r) begin
      ssCnt_r    <= ssCnt_r + 18'h00001;
      ssActive_r <= (ssCnt_r != SS_LAST);
    end
  end

  always_comb begin
    ovldCnt_nxt = ovldCnt_r;
    if (!running)       ovldCnt_nxt = '0;
    else if (cycleEnd)  ovldCnt_nxt = limitCycle ? ovldCnt_r + 10'h001 : '0;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) ovldCnt_r <= '0;
    else        ovldCnt_r <= ovldCnt_nxt;
  end

  always_ff @(posedge clock) begin
    if (!rst_n)        skip_r <= 1'b0;
    else if (!running) skip_r <= 1'b0;
    else if (cycleEnd) skip_r <= srcHit;
  end

  // sink off till start
  // a sink hit on the first clock still wins over the cycle-start clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sinkOff_r   <= 1'b0;
      limitSeen_r <= 1'b0;
    end else begin
      sinkOff_r   <= running & (sinkHit | (sinkOff_r & ~cycleStart));
      limitSeen_r <= running & (sinkHit | (limitSeen_r & ~cycleStart));
    end
  end

  assign ovMask_nxt = flagS[F_FB_118] | (ovMask_r & flagS[F_FB_104]);

  always_ff @(posedge clock) begin
    if (!rst_n) ovMask_r <= 1'b0;
    else        ovMask_r <= ovMask_nxt;
  end

  always_comb begin
    hsOn_nxt = hsOn_r;
    if (!running)                             hsOn_nxt = 1'b0;
    else if (cycleStart)                      hsOn_nxt = ~skip_r & ~ovMask_nxt & bootOk;
    else if (peakHit | ovMask_nxt | ~bootOk)  hsOn_nxt = 1'b0;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) hsOn_r <= 1'b0;
    else        hsOn_r <= hsOn_nxt;
  end

  // forced continuous low-side
  // the low-side fills every gap of the high-side except after a sink hit in that cycle, so light load never skips
  wire hsReq = hsOn_r & ~ovMask_r & bootOk;
  wire lsReq = running & ~hsOn_r & ~sinkOff_r & ~sinkHit;

  // break before make
  // each gate turns on only after the other flop has already been low one clock
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hsGate_r <= 1'b0;
      lsGate_r <= 1'b0;
    end else begin
      hsGate_r <= hsReq & ~lsGate_r & ~lsReq;
      lsGate_r <= lsReq & ~hsGate_r & ~hsReq;
    end
  end

  // fault state indications
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ovlState_r   <= 1'b0;
      thermState_r <= 1'b0;
    end else begin
      ovlState_r   <= (state_nxt == BFS_OC_HICCUP);
      thermState_r <= (state_nxt == BFS_THERM_WAIT) | (state_nxt == BFS_THERM_HICCUP);
    end
  end

  // register decode
  wire selCtrl = (regAddr == ADDR_CTRL);
  wire selStat = (regAddr == ADDR_STATUS);
  wire selOvld = (regAddr == ADDR_OVLD);

  logic [31:0] statusWord;
  always_comb begin
    statusWord               = '0;
    statusWord[ST_RUNNING]   = running;
    statusWord[ST_PREBIAS]   = (state_r == BFS_PREBIAS);
    statusWord[ST_OC_HICCUP] = ovlState_r;
    statusWord[ST_THERM]     = thermState_r;
    statusWord[ST_OV_MASK]   = ovMask_r;
    statusWord[ST_SKIP]      = skip_r;
    statusWord[ST_SS_ACTIVE] = ssActive_r;
    statusWord[ST_HS]        = hsGate_r;
    statusWord[ST_LS]        = lsGate_r;
  end

  // unmapped reads return zero; the write only keeps the run bit
  wire [31:0] rdMux = selCtrl ? ctrl_r :
                      selStat ? statusWord :
                      selOvld ? {22'h0, ovldCnt_r} : 32'h0000_0000;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_r   <= CTRL_RESET;
      rdData_r <= '0;
    end else begin
      if (regWr && selCtrl) ctrl_r <= regWrData & CTRL_RESET;
      rdData_r <= regRd ? rdMux : 32'h0000_0000;
    end
  end

  assign regRdData       = rdData_r;
  assign hsGate          = hsGate_r;
  assign lsGate          = lsGate_r;
  assign softStartActive = ssActive_r;
  assign overloadHiccup  = ovlState_r;
  assign thermalShutdown = thermState_r;

endmodule : bfs_sequencer

/* src/bfs_pkg.sv */
package bfs_pkg;

  // clock and switching rates
  localparam int          CLK_HZ        = 40_000_000;
  localparam int          SW_HZ         = 350_000;
  // whole clocks per switching cycle, rounded down
  localparam int          CYCLE_CLOCKS  = CLK_HZ / SW_HZ;
  localparam int          PHASE_W       = 7;
  localparam logic [6:0]  PHASE_FIRST   = 7'h00;
  localparam logic [6:0]  PHASE_LAST    = 7'(CYCLE_CLOCKS - 1);

  // overload persistence and restart waits, in switching cycles
  localparam logic [9:0]  OVERLOAD_LIMIT       = 10'h200;
  localparam int          OC_HICCUP_CYCLES_DEF = 16384;
  localparam int          TH_HICCUP_CYCLES_DEF = 32768;
  localparam int          HIC_W                = 16;

  // soft-start ramp time
  localparam int          SS_TIME_US     = 5000;
  localparam int          SS_CLOCKS_DEF  = SS_TIME_US * (CLK_HZ / 1_000_000);
  localparam int          SS_W           = 18;

  // comparator flag bundle, bit positions
  localparam int          FLAG_W         = 11;
  localparam int          F_ENABLE       = 0;
  localparam int          F_UVLO_OK      = 1;
  localparam int          F_BOOT_OK      = 2;
  localparam int          F_PEAK         = 3;
  localparam int          F_SRC_LIM      = 4;
  localparam int          F_SINK_LIM     = 5;
  localparam int          F_FB_118       = 6;
  localparam int          F_FB_104       = 7;
  localparam int          F_TEMP_165     = 8;
  localparam int          F_TEMP_155     = 9;
  localparam int          F_SS_ABOVE_FB  = 10;

  // register port
  localparam int          ADDR_W         = 4;
  localparam logic [3:0]  ADDR_CTRL      = 4'h0;
  localparam logic [3:0]  ADDR_STATUS    = 4'h4;
  localparam logic [3:0]  ADDR_OVLD      = 4'h8;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0001;
  localparam int          CTRL_RUN_BIT   = 0;

  // status field positions
  localparam int          ST_RUNNING     = 0;
  localparam int          ST_PREBIAS     = 1;
  localparam int          ST_OC_HICCUP   = 2;
  localparam int          ST_THERM       = 3;
  localparam int          ST_OV_MASK     = 4;
  localparam int          ST_SKIP        = 5;
  localparam int          ST_SS_ACTIVE   = 6;
  localparam int          ST_HS          = 7;
  localparam int          ST_LS          = 8;

  typedef enum {
    BFS_IDLE,
    BFS_PREBIAS,
    BFS_RUN,
    BFS_OC_HICCUP,
    BFS_THERM_WAIT,
    BFS_THERM_HICCUP
  } bfs_state_type;

endpackage : bfs_pkg

/* src/bfs_flag_sync.sv */
module bfs_flag_sync
  import bfs_pkg::*;
#(
  parameter int W = FLAG_W
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] flagsIn,
  output logic      [W-1:0] flagsOut
);

  logic [W-1:0] stage1_r;

  // two flops per flag; only the second stage is ever read outside
  for (genvar i = 0; i < W; i++) begin : g_sync
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        stage1_r[i] <= 1'b0;
        flagsOut[i] <= 1'b0;
      end else begin
        stage1_r[i] <= flagsIn[i];
        flagsOut[i] <= stage1_r[i];
      end
    end
  end

endmodule : bfs_flag_sync

/* tb/bfs_sequencer_props.sv */
module bfs_sequencer_props (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic enablePin,
  input wire logic bootReserveOk,
  input wire logic peakCurrentTrip,
  input wire logic sinkLimitTrip,
  input wire logic fbAbove118,
  input wire logic tempAbove165,
  input wire logic hsGate,
  input wire logic lsGate,
  input wire logic softStartActive,
  input wire logic overloadHiccup,
  input wire logic thermalShutdown
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // a gate that has just been released
  sequence hs_drop;
    hsGate ##1 !hsGate;
  endsequence
  sequence ls_drop;
    lsGate ##1 !lsGate;
  endsequence
  chk_no_overlap: assert property (!(hsGate && lsGate)) else $error("gates overlap");
  chk_dead_hs: assert property (hs_drop |-> !lsGate) else $error("no dead time");
  chk_dead_ls: assert property (ls_drop |-> !hsGate) else $error("no dead time");
  // peak ends pulse; flags pass two flops first
  chk_peak_ends: assert property (peakCurrentTrip [*3] |-> ##[0:3] !hsGate) else $error("peak");
  chk_sink_kills: assert property (sinkLimitTrip [*3] |-> ##[0:3] !lsGate) else $error("sink");
  chk_ovp_off: assert property (fbAbove118 [*5] |=> !hsGate) else $error("ovp");
  chk_boot_low: assert property (!bootReserveOk [*5] |=> !hsGate) else $error("boot");
  chk_hot_stop: assert property (tempAbove165 [*5] |=> thermalShutdown && !hsGate && !lsGate)
    else $error("thermal");
  chk_hiccup_off: assert property (overloadHiccup [*2] |-> !hsGate && !lsGate)
    else $error("hiccup");
  chk_prebias_off: assert property ($rose(softStartActive) |-> !hsGate && !lsGate)
    else $error("prebias");
  chk_idle_off: assert property (!enablePin [*5] |=> !hsGate && !lsGate) else $error("idle");
endmodule : bfs_sequencer_props

bind bfs_sequencer bfs_sequencer_props u_props (.clock, .rst_n, .enablePin, .bootReserveOk,
  .peakCurrentTrip, .sinkLimitTrip, .fbAbove118, .tempAbove165, .hsGate, .lsGate,
  .softStartActive, .overloadHiccup, .thermalShutdown);

/* tb/bfs_stage_model.sv */
module bfs_stage_model (
  input  wire logic       clock,
  input  wire logic       hsGate,
  input  wire logic       lsGate,
  input  wire logic [6:0] peakDelay,
  input  wire logic       srcLoad,
  input  wire logic       sinkLoad,
  output logic            peakCurrentTrip,
  output logic            srcLimitTrip,
  output logic            sinkLimitTrip
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] onTime_r;
  // high-side on-time in clocks stands in for the current ramp
  always_ff @(posedge clock) begin
    onTime_r <= hsGate ? onTime_r + 7'h01 : 7'h00;
  end
  // zero delay means the ramp never meets the reference: full duty
  assign peakCurrentTrip = hsGate && (peakDelay != 7'h00) && (onTime_r >= peakDelay);
  // limits are sensed only while the low side conducts
  assign srcLimitTrip    = lsGate && srcLoad;
  assign sinkLimitTrip   = lsGate && sinkLoad;
endmodule : bfs_stage_model

/* tb/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import bfs_pkg::*;
  localparam int P = CYCLE_CLOCKS;
  logic              clock, rst_n, enablePin, uvloOk, bootReserveOk, softStartAboveFb;
  logic              peakCurrentTrip, srcLimitTrip, sinkLimitTrip, fbAbove118, fbAbove104;
  logic              tempAbove165, tempAbove155, regWr, regRd, srcLoad, sinkLoad;
  logic              hsGate, lsGate, softStartActive, overloadHiccup, thermalShutdown;
  logic [ADDR_W-1:0] regAddr;
  logic [31:0]       regWrData, regRdData, rdv;
  logic [6:0]        peakDelay;
  int                failures, checks, n, hi, ris;
  int                cyc = 0;

  // short restart waits keep the run inside the cycle budget
  bfs_sequencer #(.SS_CLOCKS(200), .OC_HICCUP_CYCLES(4), .TH_HICCUP_CYCLES(4)) uut (.clock,
    .rst_n, .enablePin, .uvloOk, .bootReserveOk, .peakCurrentTrip, .srcLimitTrip,
    .sinkLimitTrip, .fbAbove118, .fbAbove104, .tempAbove165, .tempAbove155, .softStartAboveFb,
    .regAddr, .regWrData, .regWr, .regRd, .regRdData, .hsGate, .lsGate, .softStartActive,
    .overloadHiccup, .thermalShutdown);
  bfs_stage_model stage (.clock, .hsGate, .lsGate, .peakDelay, .srcLoad, .sinkLoad,
    .peakCurrentTrip, .srcLimitTrip, .sinkLimitTrip);

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk_bit(string nm, logic e, logic g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic chk_word(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  function automatic logic sel(int k);
    case (k)
      0: return hsGate;
      1: return lsGate;
      2: return overloadHiccup;
      default: return thermalShutdown;
    endcase
  endfunction : sel

  // sample just after the edge so registered outputs have landed
  task automatic tick(int t);
    repeat (t) @(posedge clock);
    #1;
  endtask : tick

  // settle first so a caller standing on the edge never reads a stale output
  task automatic waitv(int k, logic v, int lim);
    n = 0;
    #1;
    while (sel(k) !== v && n < lim) begin
      tick(1);
      n++;
    end
  endtask : waitv

  task automatic rise(int k, int lim);
    waitv(k, 1'b0, lim);
    waitv(k, 1'b1, lim);
  endtask : rise

  task automatic cnt(int k, int len);
    logic p;
    hi = 0;
    ris = 0;
    repeat (len) begin
      p = sel(k);
      tick(1);
      if (sel(k) === 1'b1) hi++;
      if (sel(k) === 1'b1 && p === 1'b0) ris++;
    end
  endtask : cnt

  task automatic wr(logic [ADDR_W-1:0] a, logic [31:0] d);
    @(posedge clock);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge clock);
    regWr     <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(logic [ADDR_W-1:0] a);
    @(posedge clock);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clock);
    regRd   <= 1'b0;
    #1;
    rdv = regRdData;
  endtask : rd

  initial begin
    {rst_n, regWr, regRd, regAddr, regWrData, srcLoad, sinkLoad} = '0;
    {fbAbove118, fbAbove104, tempAbove165, tempAbove155, softStartAboveFb} = '0;
    {enablePin, uvloOk, bootReserveOk} = 3'h7;
    peakDelay = 7'h28;
    void'($urandom(10908));
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    rd(ADDR_CTRL);
    chk_word("ctrl reset", CTRL_RESET, rdv);
    wr(4'hC, $urandom);
    rd(4'hC);
    chk_word("unmapped", 32'h0, rdv);
    // feedback above soft-start holds both off
    tick(30);
    chk_bit("prebias gates", 1'b0, hsGate | lsGate);
    chk_bit("ss running", 1'b1, softStartActive);
    @(posedge clock) softStartAboveFb <= 1'b1;
    rise(0, 3 * P);
    chk_bit("start", 1'b1, hsGate);
    // one pulse each period at any load
    repeat (2) begin
      @(posedge clock) peakDelay <= 7'($urandom_range(90, 10));
      rise(0, 2 * P);
      cnt(0, 5 * P);
      chk_bit("pulse rate", 1'b1, ris == 5);
    end
    // ramp of 200 clocks is long over after ten periods
    chk_bit("ss done", 1'b0, softStartActive);
    // full duty while boot reserve holds
    @(posedge clock) peakDelay <= 7'h00;
    rise(0, 2 * P);
    cnt(0, 3 * P);
    chk_bit("full duty", 1'b1, hi == 3 * P);
    @(posedge clock) bootReserveOk <= 1'b0;
    tick(8);
    chk_bit("boot low", 1'b0, hsGate);
    @(posedge clock) begin
      bootReserveOk <= 1'b1;
      peakDelay     <= 7'($urandom_range(60, 10));
    end
    @(posedge clock) begin
      fbAbove118 <= 1'b1;
      fbAbove104 <= 1'b1;
    end
    tick(8);
    cnt(0, 3 * P);
    chk_bit("ovp", 1'b1, hi == 0);
    @(posedge clock) fbAbove118 <= 1'b0;
    cnt(0, 2 * P);
    chk_bit("ovp band", 1'b1, hi == 0);
    @(posedge clock) fbAbove104 <= 1'b0;
    rise(0, 2 * P);
    chk_bit("ovp release", 1'b1, hsGate);
    rise(0, 2 * P);
    @(posedge clock) srcLoad <= 1'b1;
    tick(P);
    cnt(0, 3 * P);
    chk_bit("skip hs", 1'b1, hi == 0);
    cnt(1, P);
    chk_bit("ls held", 1'b1, hi == P);
    rd(ADDR_OVLD);
    chk_bit("ovld count", 1'b1, rdv inside {[4:6]});
    @(posedge clock) srcLoad <= 1'b0;
    rise(0, 2 * P);
    chk_bit("resume", 1'b1, hsGate);
    tick(2 * P);
    rd(ADDR_OVLD);
    chk_word("ovld clear", 32'h0, rdv);
    // sink limit cuts low side for the cycle
    @(posedge clock) sinkLoad <= 1'b1;
    cnt(1, 2 * P);
    chk_bit("sink cut", 1'b1, hi < 16);
    @(posedge clock) sinkLoad <= 1'b0;
    // a clean cycle must clear the sink count before the overload run starts
    tick(2 * P);
    rise(0, 2 * P);
    @(posedge clock) srcLoad <= 1'b1;
    waitv(2, 1'b1, 515 * P);
    chk_bit("hiccup entry", 1'b1, n > 512 * P + 40 && n < 513 * P + 24);
    @(posedge clock) srcLoad <= 1'b0;
    rd(ADDR_STATUS);
    chk_bit("hiccup flag", 1'b1, rdv[ST_OC_HICCUP]);
    waitv(2, 1'b0, 6 * P);
    chk_bit("hiccup wait", 1'b1, n > 3 * P + 60 && n <= 4 * P + 8);
    chk_bit("ss restart", 1'b1, softStartActive);
    rise(0, 3 * P);
    chk_bit("restart", 1'b1, hsGate);
    @(posedge clock) begin
      tempAbove165 <= 1'b1;
      tempAbove155 <= 1'b1;
    end
    tick(8);
    chk_bit("hot", 1'b1, thermalShutdown);
    @(posedge clock) tempAbove165 <= 1'b0;
    tick(6 * P);
    chk_bit("warm hold", 1'b1, thermalShutdown);
    @(posedge clock) tempAbove155 <= 1'b0;
    waitv(3, 1'b0, 6 * P);
    chk_bit("cool wait", 1'b1, n > 3 * P && n <= 4 * P + 8);
    rise(0, 3 * P);
    chk_bit("therm restart", 1'b1, hsGate);
    // run bit and enable pin both stop switching
    wr(ADDR_CTRL, $urandom & 32'hFFFF_FFFE);
    tick(8);
    chk_bit("run off", 1'b0, hsGate | lsGate);
    rd(ADDR_CTRL);
    chk_word("ctrl bits", 32'h0, rdv);
    wr(ADDR_CTRL, 32'h1);
    rise(0, 3 * P);
    chk_bit("run on", 1'b1, hsGate);
    // input below lockout stops switching, recovery restarts it
    @(posedge clock) uvloOk <= 1'b0;
    tick(8);
    chk_bit("lockout", 1'b0, hsGate | lsGate);
    @(posedge clock) uvloOk <= 1'b1;
    rise(0, 3 * P);
    chk_bit("lockout release", 1'b1, hsGate);
    @(posedge clock) enablePin <= 1'b0;
    tick(8);
    rd(ADDR_STATUS);
    chk_bit("idle", 1'b0, rdv[ST_RUNNING]);
    wrap_up();
  end
endmodule : testbench
